// [rtl/cit_timer.sv]
// 8-bit input capture / interval timer with noise canceller
// Notes on behaviour
// RULE1: Counter is 8-bit, up by one per selected counting clock pulse.
// RULE2: Clock select 00 sys/64, 01 sys/32, 10 sys/2, 11 watch/2.
// RULE3: Pin select 1 gives input capture, 0 gives interval timer.
// RULE4: Software cannot reach the counter; only capture registers show it.
// RULE5: Reset zeroes mode, counter, captures; counting sys/64 starts at once.
// RULE6: Falling capture edge copies counter into falling capture register.
// RULE7: Rising capture edge copies counter into rising capture register.
// RULE8: Edge matching edge select sets request; interrupt also needs enable.
// RULE9: Clear select 00 never, 01 falling, 10 rising, 11 both edges.
// RULE10: Wrap with capture signal high sets high overflow flag.
// RULE11: Wrap with capture signal low or interval mode sets low flag.
// RULE12: Overflow flags clear only by writing 0 after reading 1.
// RULE13: Overflow set with overflow enable sets the interrupt request.
// RULE14: Canceller is five sample stages plus match detector, filter enabled.
// RULE15: Sampling uses system clock when off, counting clock when on.
// RULE16: Filter output follows only when all five stages agree.
// RULE17: After reset filter output valid only after five low samples.
// RULE18: Software must expect spurious edges when switching select bits.
// RULE19: Filtered edges lag the pin by five sampling periods.
// RULE20: Pin is synchronised; all decisions use one capture signal.
`timescale 1ns/10ps
`include "cit_cfg.svh"
module cit_timer (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic capture_pin, // External capture pulse pin
  input wire logic watch_clk, // Watch clock, sampled as a level
  input wire logic [`CIT_ADDR_W-1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after the strobe
  output logic irq_out // Timer interrupt to the processor
);
  // Register state
  logic ovf_high_r;
  logic ovf_low_r;
  logic ovf_high_armed_r;
  logic ovf_low_armed_r;
  logic overflow_irq_enable_r;
  logic capture_irq_edge_sel_r;
  cit_pkg::cit_clr_type clr_sel_r;
  cit_pkg::cit_cks_type clk_sel_r;
  logic capture_pin_select_r;
  logic filter_enable_r;
  logic timer_irq_enable_r;
  logic timer_irq_request_r;
  logic [7:0] falling_capture_value_r;
  logic [7:0] rising_capture_value_r;
  logic [7:0] capture_counter_r;
  logic [7:0] rdata_r;
  logic irq_r;
  // Synchronisers
  logic pin_s1_r;
  logic pin_s2_r;
  logic wclk_s1_r;
  logic wclk_s2_r;
  logic wclk_d_r;
  logic whalf_r;
  // Prescaler and filter
  logic [5:0] presc_r;
  logic [`CIT_FILT_LEN-1:0] filt_sh_r;
  logic [`CIT_FILT_LEN-1:0] filt_sh_nxt;
  logic filt_out_r;
  logic filt_init_r;
  logic cap_d_r;
  // Combinational
  logic cnt_tick;
  logic samp_en;
  logic cap_sig;
  logic cap_rise;
  logic cap_fall;
  logic cnt_clear;
  logic cnt_wrap;
  logic set_overflow_high_flag;
  logic set_overflow_low_flag;
  logic set_req;
  logic wr_mode;
  logic wr_ctrl;
  logic rd_mode;

  assign wr_mode = reg_wr && (reg_addr == `CIT_OFS_MODE);
  assign wr_ctrl = reg_wr && (reg_addr == `CIT_OFS_CTRL);
  assign rd_mode = reg_rd && (reg_addr == `CIT_OFS_MODE);

  // Two-stage synchronisers for pin and watch clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      wclk_s1_r <= 1'b0;
      wclk_s2_r <= 1'b0;
      wclk_d_r <= 1'b0;
    end else begin
      pin_s1_r <= capture_pin; // RULE20
      pin_s2_r <= pin_s1_r; // RULE20
      wclk_s1_r <= watch_clk;
      wclk_s2_r <= wclk_s1_r;
      wclk_d_r <= wclk_s2_r;
    end
  end

  // Free-running system clock prescaler and watch clock halver
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_r <= `CIT_PRESC_RST;
      whalf_r <= 1'b0;
    end else begin
      presc_r <= presc_r + 6'h01;
      if (wclk_s2_r && !wclk_d_r) begin
        whalf_r <= !whalf_r;
      end
    end
  end

  // One-cycle counting pulse for the selected clock
  always_comb begin
    case (clk_sel_r) // RULE2
      cit_pkg::CIT_CKS_DIV64: cnt_tick = (presc_r == `CIT_DIV64_END);
      cit_pkg::CIT_CKS_DIV32: cnt_tick = (presc_r[4:0] == `CIT_DIV32_END);
      cit_pkg::CIT_CKS_DIV2: cnt_tick = presc_r[0];
      cit_pkg::CIT_CKS_WATCH2: cnt_tick = whalf_r && wclk_s2_r && !wclk_d_r;
      default: cnt_tick = 1'b0;
    endcase
  end

  // Sampling clock: every cycle when bypassed, counting clock when filtering
  assign samp_en = filter_enable_r ? cnt_tick : 1'b1; // RULE15

  // Match is judged on the stages including the sample just taken,
  // so the output moves at the fifth agreeing sample, not the sixth
  assign filt_sh_nxt = {filt_sh_r[`CIT_FILT_LEN-2:0], pin_s2_r}; // RULE14

  // Five-stage sampler with match detector
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_sh_r <= `CIT_FILT_RST;
      filt_out_r <= 1'b0;
      filt_init_r <= 1'b0;
    end else if (samp_en) begin
      filt_sh_r <= filt_sh_nxt; // RULE14
      if (filt_sh_nxt == `CIT_FILT_ZERO) begin
        filt_out_r <= 1'b0; // RULE16
        filt_init_r <= 1'b1; // RULE17
      end else if (&filt_sh_nxt && filt_init_r) begin
        filt_out_r <= 1'b1; // RULE16 RULE19
      end
    end
  end

  // Internal capture signal is low whenever the pin is not used for capture
  always_comb begin
    if (!capture_pin_select_r) begin
      cap_sig = 1'b0; // RULE3
    end else if (filter_enable_r) begin
      cap_sig = filt_out_r; // RULE14
    end else begin
      cap_sig = pin_s2_r; // RULE20
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_d_r <= 1'b0;
    end else begin
      cap_d_r <= cap_sig;
    end
  end

  assign cap_rise = cap_sig && !cap_d_r;
  assign cap_fall = !cap_sig && cap_d_r;

  always_comb begin
    case (clr_sel_r) // RULE9
      cit_pkg::CIT_CLR_NONE: cnt_clear = 1'b0;
      cit_pkg::CIT_CLR_FALL: cnt_clear = cap_fall;
      cit_pkg::CIT_CLR_RISE: cnt_clear = cap_rise;
      cit_pkg::CIT_CLR_BOTH: cnt_clear = cap_rise || cap_fall;
      default: cnt_clear = 1'b0;
    endcase
  end

  assign cnt_wrap = cnt_tick && !cnt_clear && (capture_counter_r == `CIT_CNT_MAX);
  assign set_overflow_high_flag = cnt_wrap && cap_sig; // RULE10
  assign set_overflow_low_flag = cnt_wrap && !cap_sig; // RULE11

  // Counter, not visible on the register port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_counter_r <= `CIT_CNT_RST; // RULE5
    end else if (cnt_clear) begin
      capture_counter_r <= `CIT_CNT_RST; // RULE9
    end else if (cnt_tick) begin
      capture_counter_r <= capture_counter_r + 8'h01; // RULE1
    end
  end

  // Capture registers take the value before any clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      falling_capture_value_r <= `CIT_CNT_RST; // RULE5
      rising_capture_value_r <= `CIT_CNT_RST; // RULE5
    end else begin
      if (cap_fall) begin
        falling_capture_value_r <= capture_counter_r; // RULE6
      end
      if (cap_rise) begin
        rising_capture_value_r <= capture_counter_r; // RULE7
      end
    end
  end

  // Mode register control fields
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_irq_enable_r <= 1'b0;
      capture_irq_edge_sel_r <= 1'b0;
      clr_sel_r <= cit_pkg::CIT_CLR_NONE;
      clk_sel_r <= cit_pkg::CIT_CKS_DIV64; // RULE5
    end else if (wr_mode) begin
      overflow_irq_enable_r <= reg_wdata[`CIT_BIT_OVERFLOW_IRQ_ENABLE];
      capture_irq_edge_sel_r <= reg_wdata[`CIT_BIT_EDGE];
      clr_sel_r <= cit_pkg::cit_clr_type'(reg_wdata[`CIT_BIT_CCLR_HI:`CIT_BIT_CCLR_LO]);
      clk_sel_r <= cit_pkg::cit_cks_type'(reg_wdata[`CIT_BIT_CKS_HI:`CIT_BIT_CKS_LO]);
    end
  end

  // Overflow flags: set wins, clear by 0 only after a read showed 1
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_high_r <= 1'b0;
      ovf_low_r <= 1'b0;
      ovf_high_armed_r <= 1'b0;
      ovf_low_armed_r <= 1'b0;
    end else begin
      if (set_overflow_high_flag) begin
        ovf_high_r <= 1'b1; // RULE10
      end else if (wr_mode && !reg_wdata[`CIT_BIT_OVERFLOW_HIGH_FLAG] && ovf_high_armed_r) begin
        ovf_high_r <= 1'b0; // RULE12
      end
      if (set_overflow_low_flag) begin
        ovf_low_r <= 1'b1; // RULE11
      end else if (wr_mode && !reg_wdata[`CIT_BIT_OVERFLOW_LOW_FLAG] && ovf_low_armed_r) begin
        ovf_low_r <= 1'b0; // RULE12
      end
      if (rd_mode && ovf_high_r) begin
        ovf_high_armed_r <= 1'b1; // RULE12
      end else if (wr_mode || !ovf_high_r) begin
        ovf_high_armed_r <= 1'b0;
      end
      if (rd_mode && ovf_low_r) begin
        ovf_low_armed_r <= 1'b1; // RULE12
      end else if (wr_mode || !ovf_low_r) begin
        ovf_low_armed_r <= 1'b0;
      end
    end
  end

  // Interrupt request sources
  always_comb begin
    set_req = 1'b0;
    if (capture_irq_edge_sel_r ? cap_fall : cap_rise) begin
      set_req = 1'b1; // RULE8
    end
    if (overflow_irq_enable_r && (set_overflow_high_flag || set_overflow_low_flag)) begin
      set_req = 1'b1; // RULE13
    end
  end

  // Port select, filter select, interrupt enable and request flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capture_pin_select_r <= 1'b0;
      filter_enable_r <= 1'b0;
      timer_irq_enable_r <= 1'b0;
      timer_irq_request_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        capture_pin_select_r <= reg_wdata[`CIT_BIT_PIN_SEL]; // RULE3 RULE18
        filter_enable_r <= reg_wdata[`CIT_BIT_FILT_EN]; // RULE14 RULE18
        timer_irq_enable_r <= reg_wdata[`CIT_BIT_IRQ_EN];
      end
      if (set_req) begin
        timer_irq_request_r <= 1'b1; // RULE8 RULE13
      end else if (wr_ctrl && !reg_wdata[`CIT_BIT_IRQ_REQ]) begin
        timer_irq_request_r <= 1'b0;
      end
    end
  end

  // Processor interrupt needs both request and enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= timer_irq_request_r && timer_irq_enable_r; // RULE8 RULE13
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr) // RULE4
        `CIT_OFS_MODE: rdata_r <= {ovf_high_r, ovf_low_r, overflow_irq_enable_r,
          capture_irq_edge_sel_r, clr_sel_r, clk_sel_r};
        `CIT_OFS_FALL: rdata_r <= falling_capture_value_r;
        `CIT_OFS_RISE: rdata_r <= rising_capture_value_r;
        `CIT_OFS_CTRL: rdata_r <= {4'h0, timer_irq_request_r, timer_irq_enable_r,
          filter_enable_r, capture_pin_select_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_out = irq_r;
endmodule

// [rtl/cit_cfg.svh]
// Offsets, field positions and reset values of the capture interval timer
`ifndef CIT_CFG_SVH
`define CIT_CFG_SVH
`define CIT_ADDR_W 2
`define CIT_OFS_MODE 2'h0
`define CIT_OFS_FALL 2'h1
`define CIT_OFS_RISE 2'h2
`define CIT_OFS_CTRL 2'h3
`define CIT_BIT_OVERFLOW_HIGH_FLAG 7
`define CIT_BIT_OVERFLOW_LOW_FLAG 6
`define CIT_BIT_OVERFLOW_IRQ_ENABLE 5
`define CIT_BIT_EDGE 4
`define CIT_BIT_CCLR_HI 3
`define CIT_BIT_CCLR_LO 2
`define CIT_BIT_CKS_HI 1
`define CIT_BIT_CKS_LO 0
`define CIT_BIT_PIN_SEL 0
`define CIT_BIT_FILT_EN 1
`define CIT_BIT_IRQ_EN 2
`define CIT_BIT_IRQ_REQ 3
`define CIT_MODE_RST 8'h00
`define CIT_CTRL_RST 4'h0
`define CIT_CNT_RST 8'h00
`define CIT_CNT_MAX 8'hFF
`define CIT_PRESC_RST 6'h00
`define CIT_DIV64_END 6'h3F
`define CIT_DIV32_END 5'h1F
`define CIT_FILT_LEN 5
`define CIT_FILT_RST 5'h1F
`define CIT_FILT_ZERO 5'h00
`endif

// [rtl/cit_pkg.sv]
// Types shared by the capture interval timer
package cit_pkg;
  typedef enum logic [1:0] {
    CIT_CKS_DIV64 = 2'h0,
    CIT_CKS_DIV32 = 2'h1,
    CIT_CKS_DIV2 = 2'h2,
    CIT_CKS_WATCH2 = 2'h3
  } cit_cks_type;
  typedef enum logic [1:0] {
    CIT_CLR_NONE = 2'h0,
    CIT_CLR_FALL = 2'h1,
    CIT_CLR_RISE = 2'h2,
    CIT_CLR_BOTH = 2'h3
  } cit_clr_type;
endpackage

// [bench/cit_pulse_src.sv]
// External pulse source that drives the capture pin
`timescale 1ns/10ps
module cit_pulse_src (
  input wire logic clk, // System clock
  output logic capture_pin // Pin level
);
  initial capture_pin = 1'b0;
  // Level changes just after an edge and is held at least two clocks by every caller
  task automatic hold(input logic lvl, input int n);
    capture_pin <= lvl;
    repeat (n) @(posedge clk);
  endtask
endmodule

// [bench/cit_timer_chk.sv]
// Port assertions for the capture interval timer
`timescale 1ns/10ps
module cit_timer_chk (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic capture_pin, // Pin
  input wire logic watch_clk, // Watch clock
  input wire logic [1:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic irq_out // Interrupt
);
  logic [5:0] mode_r;
  logic [2:0] ctrl_r;
  logic [9:0] age_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of software-written fields
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= 6'h00;
      ctrl_r <= 3'h0;
    end else if (reg_wr && reg_addr == 2'h0) begin
      mode_r <= reg_wdata[5:0];
    end else if (reg_wr && reg_addr == 2'h3) begin
      ctrl_r <= reg_wdata[2:0];
    end
  end
  // Cycles since reset, saturating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_r <= 10'h000;
    end else if (age_r != 10'h3FF) begin
      age_r <= age_r + 10'h001;
    end
  end
  sequence s_read(logic [1:0] a);
    $past(reg_rd) && $past(reg_addr) == a;
  endsequence
  sequence s_rise_armed;
    $rose(capture_pin) && ctrl_r == 3'h5 && !mode_r[4];
  endsequence
  a_mode_readback: assert property (s_read(2'h0) |-> reg_rdata[5:0] == $past(mode_r))
    else $error("mode read differs from written fields");
  a_ctrl_readback: assert property (s_read(2'h3) |->
    reg_rdata[2:0] == $past(ctrl_r) && reg_rdata[7:4] == 4'h0)
    else $error("control read differs from written bits");
  a_irq_needs_en: assert property (irq_out |-> $past(ctrl_r[2]))
    else $error("interrupt without enable");
  a_rise_request: assert property (s_rise_armed |-> ##[3:5] irq_out)
    else $error("rising capture gave no interrupt");
  a_fall_only_quiet: assert property ($rose(capture_pin) && ctrl_r == 3'h5 &&
    mode_r[5:4] == 2'h1 && !irq_out |-> (!irq_out) [*6])
    else $error("rising edge requested with falling select");
  a_flags_start_clear: assert property (s_read(2'h0) ##0 (age_r < 10'h1F4) |->
    reg_rdata[7:6] == 2'h0)
    else $error("overflow flag before any wrap");
  a_irq_reset_low: assert property (age_r < 10'h002 |-> !irq_out)
    else $error("interrupt high after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule
bind cit_timer cit_timer_chk u_chk (.clk(clk), .sys_rst(sys_rst), .capture_pin(capture_pin),
  .watch_clk(watch_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));

// [bench/cit_timer_test.sv]
// Self-checking bench for the capture interval timer
`timescale 1ns/10ps
module cit_timer_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic watch_clk = 1'b0;
  logic [2:0] wdiv = 3'h0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_out;
  logic capture_pin;
  logic [7:0] f, r;
  logic [7:0] exp_cnt [4] = '{8'h02, 8'h04, 8'h40, 8'h08};
  int fails = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  // Watch clock at one eighth of the system clock
  always @(posedge clk) begin
    wdiv <= wdiv + 3'h1;
    watch_clk <= wdiv[2];
  end
  cit_pulse_src src (.clk(clk), .capture_pin(capture_pin));
  cit_timer dut (.clk(clk), .sys_rst(sys_rst), .capture_pin(capture_pin),
    .watch_clk(watch_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand for the cycle after the strobe; take them mid-cycle
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask
  // Rise, low gap, rise, fall; captures then hold known tick counts
  task automatic run_case(input logic [7:0] m, input int h, input int l);
    wr(2'h0, m);
    src.hold(1'b1, h);
    src.hold(1'b0, l);
    src.hold(1'b1, h);
    src.hold(1'b0, 8);
    rd(2'h1, f);
    rd(2'h2, r);
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), f);
      check("reset value", f, 8'h00);
    end
    wr(2'h0, 8'hEF);
    wr(2'h1, 8'hAA);
    wr(2'h2, 8'hAA);
    rd(2'h0, f);
    check("mode", f, 8'h2F);
    rd(2'h1, f);
    check("fall capture", f, 8'h00);
    rd(2'h2, f);
    check("rise capture", f, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, f);
    check("control", f, 8'h07);
    wr(2'h3, 8'h05);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      run_case(8'h0C | 8'(i), 129, 129);
      check("fall capture", f, exp_cnt[i]);
      check("rise capture", r, exp_cnt[i]);
    end
    check("irq", {7'h00, irq_out}, 8'h01);
    $display("clock select done");
    run_case(8'h06, 129, 128);
    check("fall capture", f, 8'h80);
    run_case(8'h0A, 128, 129);
    check("rise capture", r, 8'h80);
    run_case(8'h02, 128, 128);
    check("capture gap", f - r, 8'h40);
    $display("clear select done");
    wr(2'h0, 8'h12);
    wr(2'h3, 8'h05);
    src.hold(1'b0, 2);
    src.hold(1'b1, 10);
    check("irq", {7'h00, irq_out}, 8'h00);
    src.hold(1'b0, 10);
    check("irq", {7'h00, irq_out}, 8'h01);
    wr(2'h3, 8'h09);
    rd(2'h3, f);
    check("control", f, 8'h09);
    check("irq", {7'h00, irq_out}, 8'h00);
    $display("interrupt done");
    wr(2'h3, 8'h04);
    rd(2'h0, f);
    wr(2'h0, 8'h22);
    repeat (520) @(posedge clk);
    rd(2'h0, f);
    check("mode", f, 8'h62);
    check("irq", {7'h00, irq_out}, 8'h01);
    wr(2'h0, 8'h22);
    rd(2'h0, f);
    check("mode", f, 8'h22);
    repeat (520) @(posedge clk);
    wr(2'h0, 8'h22);
    rd(2'h0, f);
    check("mode", f, 8'h62);
    src.hold(1'b1, 4);
    wr(2'h3, 8'h05);
    rd(2'h0, f);
    wr(2'h0, 8'h22);
    repeat (520) @(posedge clk);
    rd(2'h0, f);
    check("mode", f, 8'hA2);
    $display("overflow done");
    src.hold(1'b0, 4);
    wr(2'h0, 8'h02);
    wr(2'h3, 8'h07);
    src.hold(1'b0, 30);
    rd(2'h2, r);
    wr(2'h3, 8'h07);
    src.hold(1'b1, 6);
    src.hold(1'b0, 30);
    rd(2'h2, f);
    check("rise capture", f, r);
    check("irq", {7'h00, irq_out}, 8'h00);
    src.hold(1'b1, 30);
    check("irq", {7'h00, irq_out}, 8'h01);
    $display("filter done");
    end_of_test();
  end
  initial begin
    #1000000;
    fails++;
    end_of_test();
  end
endmodule
